// File: rtl/bfx_alu.sv
// Combinational arithmetic unit of the byte-file executor
`timescale 1ns/100ps
module bfx_alu (
    bfx_alu_if.alu a
);

    // ------------------------------------------------------------
    // Result and flag generation
    // ------------------------------------------------------------
    // Subtract by adding the complement plus one, so carry means no borrow
    always_comb begin
        logic [8:0] sum;
        logic [4:0] low;
        sum     = 9'h000;
        low     = 5'h00;
        a.res   = a.opnd;
        a.cout  = a.cin;
        a.dcout = 1'b0;
        case (a.op)
            bfx_pkg::ALU_DEC:  a.res = a.opnd - 8'h01;
            bfx_pkg::ALU_INC:  a.res = a.opnd + 8'h01;
            bfx_pkg::ALU_OR:   a.res = a.opnd | a.acc;
            bfx_pkg::ALU_XOR:  a.res = a.opnd ^ a.acc;
            bfx_pkg::ALU_SUB: begin
                sum     = {1'b0, a.opnd} + {1'b0, ~a.acc} + 9'h001;
                low     = {1'b0, a.opnd[3:0]} + {1'b0, ~a.acc[3:0]} + 5'h01;
                a.res   = sum[7:0];
                a.cout  = sum[8];
                a.dcout = low[4];
            end
            bfx_pkg::ALU_RLC: begin
                a.res  = {a.opnd[6:0], a.cin};
                a.cout = a.opnd[7];
            end
            bfx_pkg::ALU_RRC: begin
                a.res  = {a.cin, a.opnd[7:1]};
                a.cout = a.opnd[0];
            end
            bfx_pkg::ALU_SWAP: a.res = {a.opnd[3:0], a.opnd[7:4]};
            default:           a.res = a.opnd;
        endcase
        a.zero = (a.res == 8'h00);
    end

endmodule

// File: rtl/bfx_alu_if.sv
// Interface between the executor and its arithmetic unit
`timescale 1ns/100ps
interface bfx_alu_if;
    bfx_pkg::bfx_alu_op_t op;
    logic [7:0]           opnd;
    logic [7:0]           acc;
    logic                 cin;
    logic [7:0]           res;
    logic                 cout;
    logic                 dcout;
    logic                 zero;

    modport exec (output op, output opnd, output acc, output cin,
                  input res, input cout, input dcout, input zero);
    modport alu  (input op, input opnd, input acc, input cin,
                  output res, output cout, output dcout, output zero);
endinterface

// File: rtl/bfx_exec.sv
// Byte-file instruction executor with AXI4-Lite register access
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps

// Notes on behaviour
// - decrement file, zero flag
// - decrement, skip next on zero
// - increment file, zero flag
// - increment, skip next on zero
// - acc OR literal, zero flag
// - acc OR file, zero flag
// - literal into acc, flags kept
// - acc into file, flags kept
// - copy file, zero flag
// - rotate left through carry
// - rotate right through carry
// - literal to acc, return, two cycles
// - pop stack, return, two cycles
// - sleep clears watchdog, enters standby
// - literal minus acc, three flags
// - file minus acc, three flags
// - swap nibbles, no flags
// - acc XOR literal, zero flag
// - acc XOR file, zero flag
module bfx_exec (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_NRST,
    input  wire logic [7:0]  I_AWADDR,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    input  wire logic [7:0]  I_ARADDR,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    output logic             O_STANDBY,
    output logic             O_GIE,
    output logic             O_WDT_CLR,
    output logic             O_STACK_POP
);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_PEND   = 4'b0010,
        ST_SECOND = 4'b0100,
        ST_STBY   = 4'b1000
    } bfx_st_t;

    typedef struct packed {
        logic [127:0][7:0] file;
        logic [7:0]        acc;
        logic              c;
        logic              dc;
        logic              z;
        logic              to;
        logic              pd;
        logic              global_interrupt_enable;
        logic              skip;
        bfx_st_t           st;
        logic [13:0]       instr;
        logic [12:0]       pc;
        logic [12:0]       stk;
        logic [6:0]        faddr;
        logic [1:0]        div;
        logic              wdt_clr;
        logic              pop;
        logic              aw_full;
        logic [7:0]        awaddr;
        logic              w_full;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              awrdy;
        logic              wrdy;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arrdy;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } bfx_state_t;

    bfx_state_t s_q;
    bfx_state_t s_d;
    bfx_alu_if  alu_bus ();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte-lane merge of a bus write
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old,
        input logic [31:0] dat,
        input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Read view, also the base of merged writes
    function automatic logic [31:0] reg_view(input bfx_state_t s, input logic [7:0] adr);
        logic [31:0] r;
        r = 32'h0000_0000;
        case ({adr[7:2], 2'b00})
            bfx_pkg::OFS_INSTR:  r[13:0] = s.instr;
            bfx_pkg::OFS_ACC:    r[7:0]  = s.acc;
            bfx_pkg::OFS_STATUS: begin
                r[bfx_pkg::ST_C]    = s.c;
                r[bfx_pkg::ST_DC]   = s.dc;
                r[bfx_pkg::ST_Z]    = s.z;
                r[bfx_pkg::ST_PD]   = s.pd;
                r[bfx_pkg::ST_TO]   = s.to;
                r[bfx_pkg::ST_GIE]  = s.global_interrupt_enable;
                r[bfx_pkg::ST_SKIP] = s.skip;
                r[bfx_pkg::ST_BUSY] = (s.st == ST_PEND) || (s.st == ST_SECOND);
                r[bfx_pkg::ST_STBY] = (s.st == ST_STBY);
            end
            bfx_pkg::OFS_STACK:  r[12:0] = s.stk;
            bfx_pkg::OFS_PC:     r[12:0] = s.pc;
            bfx_pkg::OFS_FADDR:  r[6:0]  = s.faddr;
            bfx_pkg::OFS_FDATA:  r[7:0]  = s.file[s.faddr];
            default:             r       = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // Address hits a mapped word
    function automatic logic is_mapped(input logic [7:0] adr);
        return ({adr[7:2], 2'b00} <= bfx_pkg::OFS_FDATA);
    endfunction

    // ------------------------------------------------------------
    // Arithmetic unit and its operand selection
    // ------------------------------------------------------------
    bfx_alu u_alu (
        .a (alu_bus.alu)
    );

    // Literal forms use the low byte, file forms the register
    always_comb begin
        alu_bus.acc = s_q.acc;
        alu_bus.cin = s_q.c;
        alu_bus.op  = bfx_pkg::ALU_PASS;
        if (s_q.instr[13:12] == 2'b11) begin
            alu_bus.opnd = s_q.instr[7:0];
            if (s_q.instr[11:9] == 3'b110) begin
                alu_bus.op = bfx_pkg::ALU_SUB;
            end else if (s_q.instr[11:8] == bfx_pkg::LOP_OR) begin
                alu_bus.op = bfx_pkg::ALU_OR;
            end else if (s_q.instr[11:8] == bfx_pkg::LOP_XOR) begin
                alu_bus.op = bfx_pkg::ALU_XOR;
            end
        end else begin
            alu_bus.opnd = s_q.file[s_q.instr[6:0]];
            case (s_q.instr[11:8])
                bfx_pkg::BOP_DEC, bfx_pkg::BOP_DECSZ: alu_bus.op = bfx_pkg::ALU_DEC;
                bfx_pkg::BOP_INC, bfx_pkg::BOP_INCSZ: alu_bus.op = bfx_pkg::ALU_INC;
                bfx_pkg::BOP_OR:   alu_bus.op = bfx_pkg::ALU_OR;
                bfx_pkg::BOP_XOR:  alu_bus.op = bfx_pkg::ALU_XOR;
                bfx_pkg::BOP_SUB:  alu_bus.op = bfx_pkg::ALU_SUB;
                bfx_pkg::BOP_RLC:  alu_bus.op = bfx_pkg::ALU_RLC;
                bfx_pkg::BOP_RRC:  alu_bus.op = bfx_pkg::ALU_RRC;
                bfx_pkg::BOP_SWAP: alu_bus.op = bfx_pkg::ALU_SWAP;
                default:           alu_bus.op = bfx_pkg::ALU_PASS;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Bus writes first, so execution wins a clash
    always_comb begin
        logic [31:0] wm;
        logic        tick;
        logic        dst_f;
        logic [6:0]  fa;
        logic [3:0]  bop;
        wm    = 32'h0000_0000;
        s_d   = s_q;
        tick  = (s_q.div == 2'(bfx_pkg::TCY_CLKS - 1));
        dst_f = s_q.instr[7];
        fa    = s_q.instr[6:0];
        bop   = s_q.instr[11:8];
        s_d.div     = tick ? 2'h0 : s_q.div + 2'h1;
        s_d.wdt_clr = 1'b0;
        s_d.pop     = 1'b0;

        // Address and data taken in either order
        if (s_q.bvalid && I_BREADY) begin
            s_d.bvalid = 1'b0;
        end
        if (I_AWVALID && s_q.awrdy) begin
            s_d.aw_full = 1'b1;
            s_d.awaddr  = I_AWADDR;
        end
        if (I_WVALID && s_q.wrdy) begin
            s_d.w_full = 1'b1;
            s_d.wdata  = I_WDATA;
            s_d.wstrb  = I_WSTRB;
        end
        if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = bfx_pkg::RESP_OK;
            wm = lane_merge(reg_view(s_q, s_q.awaddr), s_q.wdata, s_q.wstrb);
            case ({s_q.awaddr[7:2], 2'b00})
                bfx_pkg::OFS_INSTR: begin
                    // Refused while one is in flight
                    if (s_q.st == ST_IDLE) begin
                        s_d.instr = wm[13:0];
                        s_d.st    = ST_PEND;
                    end else begin
                        s_d.bresp = bfx_pkg::RESP_ERR;
                    end
                end
                bfx_pkg::OFS_ACC:    s_d.acc = wm[7:0];
                bfx_pkg::OFS_STATUS: begin
                    s_d.c   = wm[bfx_pkg::ST_C];
                    s_d.dc  = wm[bfx_pkg::ST_DC];
                    s_d.z   = wm[bfx_pkg::ST_Z];
                    s_d.global_interrupt_enable = wm[bfx_pkg::ST_GIE];
                    if (s_q.st == ST_STBY && !wm[bfx_pkg::ST_STBY]) begin
                        s_d.st = ST_IDLE;
                    end
                end
                bfx_pkg::OFS_STACK:  s_d.stk   = wm[12:0];
                bfx_pkg::OFS_PC:     s_d.pc    = s_q.pc;
                bfx_pkg::OFS_FADDR:  s_d.faddr = wm[6:0];
                bfx_pkg::OFS_FDATA:  s_d.file[s_q.faddr] = wm[7:0];
                default:             s_d.bresp = bfx_pkg::RESP_ERR;
            endcase
        end

        // Read channel
        if (s_q.rvalid && I_RREADY) begin
            s_d.rvalid = 1'b0;
        end
        if (I_ARVALID && s_q.arrdy) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = reg_view(s_q, I_ARADDR);
            s_d.rresp  = is_mapped(I_ARADDR) ? bfx_pkg::RESP_OK : bfx_pkg::RESP_ERR;
        end

        // Execution, one instruction cycle per tick
        case (s_q.st)
            ST_IDLE, ST_STBY: begin
            end
            ST_SECOND: begin
                if (tick) begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_PEND: begin
                if (tick) begin
                    s_d.st = ST_IDLE;
                    s_d.pc = s_q.pc + 13'h0001;
                    if (s_q.skip) begin
                        // Discarded, runs as a no-op
                        s_d.skip = 1'b0;
                    end else if (s_q.instr[13:12] == 2'b11) begin
                        if (s_q.instr[11:10] == 2'b00) begin
                            s_d.acc = s_q.instr[7:0];
                        end else if (s_q.instr[11:10] == 2'b01) begin
                            s_d.acc = s_q.instr[7:0];
                            s_d.pc  = s_q.stk;
                            s_d.pop = 1'b1;
                            s_d.st  = ST_SECOND;
                        end else if (alu_bus.op != bfx_pkg::ALU_PASS) begin
                            s_d.acc = alu_bus.res;
                            s_d.z   = alu_bus.zero;
                            if (alu_bus.op == bfx_pkg::ALU_SUB) begin
                                s_d.c  = alu_bus.cout;
                                s_d.dc = alu_bus.dcout;
                            end
                        end
                    end else if (s_q.instr[13:12] == 2'b00 && bop != bfx_pkg::BOP_STORE) begin
                        if (dst_f) begin
                            s_d.file[fa] = alu_bus.res;
                        end else begin
                            s_d.acc = alu_bus.res;
                        end
                        case (bop)
                            bfx_pkg::BOP_DEC, bfx_pkg::BOP_INC, bfx_pkg::BOP_OR,
                            bfx_pkg::BOP_XOR, bfx_pkg::BOP_COPY: begin
                                s_d.z = alu_bus.zero;
                            end
                            bfx_pkg::BOP_DECSZ, bfx_pkg::BOP_INCSZ: begin
                                s_d.skip = alu_bus.zero;
                            end
                            bfx_pkg::BOP_RLC, bfx_pkg::BOP_RRC: begin
                                s_d.c = alu_bus.cout;
                            end
                            bfx_pkg::BOP_SUB: begin
                                s_d.c  = alu_bus.cout;
                                s_d.dc = alu_bus.dcout;
                                s_d.z  = alu_bus.zero;
                            end
                            default: begin
                                // Nibble swap keeps every flag
                                s_d.z = s_q.z;
                            end
                        endcase
                    end else if (s_q.instr[13:7] == 7'b0000001) begin
                        s_d.file[fa] = s_q.acc;
                    end else if (s_q.instr == bfx_pkg::OPC_RET) begin
                        s_d.pc  = s_q.stk;
                        s_d.pop = 1'b1;
                        s_d.st  = ST_SECOND;
                    end else if (s_q.instr == bfx_pkg::OPC_RETINT) begin
                        s_d.pc  = s_q.stk;
                        s_d.global_interrupt_enable = 1'b1;
                        s_d.pop = 1'b1;
                        s_d.st  = ST_SECOND;
                    end else if (s_q.instr == bfx_pkg::OPC_SLEEP) begin
                        s_d.wdt_clr = 1'b1;
                        s_d.to      = 1'b1;
                        s_d.pd      = 1'b0;
                        s_d.st      = ST_STBY;
                    end
                end
            end
            default: s_d.st = ST_IDLE;
        endcase

        // Ready terms registered from the next state
        s_d.awrdy = !s_d.aw_full && !s_d.bvalid;
        s_d.wrdy  = !s_d.w_full && !s_d.bvalid;
        s_d.arrdy = !s_d.rvalid;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            s_q       <= '0;
            s_q.st    <= ST_IDLE;
            s_q.to    <= bfx_pkg::TO_RST;
            s_q.pd    <= bfx_pkg::PD_RST;
            s_q.awrdy <= 1'b1;
            s_q.wrdy  <= 1'b1;
            s_q.arrdy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    assign O_AWREADY   = s_q.awrdy;
    assign O_WREADY    = s_q.wrdy;
    assign O_BVALID    = s_q.bvalid;
    assign O_BRESP     = s_q.bresp;
    assign O_ARREADY   = s_q.arrdy;
    assign O_RVALID    = s_q.rvalid;
    assign O_RDATA     = s_q.rdata;
    assign O_RRESP     = s_q.rresp;
    assign O_STANDBY   = s_q.st[3];
    assign O_GIE       = s_q.global_interrupt_enable;
    assign O_WDT_CLR   = s_q.wdt_clr;
    assign O_STACK_POP = s_q.pop;

endmodule

// File: rtl/bfx_pkg.sv
// Register map, opcode fields and timing of the byte-file executor
package bfx_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TCY_NS        = 80;
    // Least time, so round up
    localparam int unsigned TCY_CLKS      = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_INSTR  = 8'h00;
    localparam logic [7:0] OFS_ACC    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_STACK  = 8'h0C;
    localparam logic [7:0] OFS_PC     = 8'h10;
    localparam logic [7:0] OFS_FADDR  = 8'h14;
    localparam logic [7:0] OFS_FDATA  = 8'h18;

    // Status bit positions
    localparam int unsigned ST_C     = 0;
    localparam int unsigned ST_DC    = 1;
    localparam int unsigned ST_Z     = 2;
    localparam int unsigned ST_PD    = 3;
    localparam int unsigned ST_TO    = 4;
    localparam int unsigned ST_GIE   = 5;
    localparam int unsigned ST_SKIP  = 6;
    localparam int unsigned ST_BUSY  = 7;
    localparam int unsigned ST_STBY  = 8;

    // Reset values and response codes
    localparam logic       TO_RST   = 1'b1;
    localparam logic       PD_RST   = 1'b1;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // ------------------------------------------------------------
    // Opcode fields
    // ------------------------------------------------------------
    localparam logic [3:0] BOP_STORE = 4'h0;
    localparam logic [3:0] BOP_SUB   = 4'h2;
    localparam logic [3:0] BOP_DEC   = 4'h3;
    localparam logic [3:0] BOP_OR    = 4'h4;
    localparam logic [3:0] BOP_XOR   = 4'h6;
    localparam logic [3:0] BOP_COPY  = 4'h8;
    localparam logic [3:0] BOP_INC   = 4'hA;
    localparam logic [3:0] BOP_DECSZ = 4'hB;
    localparam logic [3:0] BOP_RRC   = 4'hC;
    localparam logic [3:0] BOP_RLC   = 4'hD;
    localparam logic [3:0] BOP_SWAP  = 4'hE;
    localparam logic [3:0] BOP_INCSZ = 4'hF;
    localparam logic [3:0] LOP_OR    = 4'h8;
    localparam logic [3:0] LOP_XOR   = 4'hA;
    localparam logic [13:0] OPC_RET    = 14'h0008;
    localparam logic [13:0] OPC_RETINT = 14'h0009;
    localparam logic [13:0] OPC_SLEEP  = 14'h0063;

    // ALU operations
    typedef enum logic [3:0] {
        ALU_PASS, ALU_DEC, ALU_INC, ALU_OR, ALU_XOR, ALU_SUB, ALU_RLC, ALU_RRC, ALU_SWAP
    } bfx_alu_op_t;

endpackage

// File: test/bfx_exec_properties.sv
// Concurrent port checks for the byte-file executor
`timescale 1ns/100ps
module bfx_exec_properties (
    input wire logic        I_CORE_CLK,
    input wire logic        I_NRST,
    input wire logic        I_AWVALID,
    input wire logic        O_AWREADY,
    input wire logic        I_WVALID,
    input wire logic        O_WREADY,
    input wire logic        O_BVALID,
    input wire logic        I_BREADY,
    input wire logic [1:0]  O_BRESP,
    input wire logic        I_ARVALID,
    input wire logic        O_ARREADY,
    input wire logic        O_RVALID,
    input wire logic        I_RREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic        O_STANDBY,
    input wire logic        O_WDT_CLR,
    input wire logic        O_STACK_POP
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);
    // Address and data taken on one edge
    sequence wr_taken;
        I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
    endsequence
    // One-cycle pulses; sleep enters standby
    wdt_pulse_a: assert property (O_WDT_CLR |=> !O_WDT_CLR) else $error("long clear");
    sleep_stby_a: assert property (O_WDT_CLR |-> ##[0:1] O_STANDBY) else $error("no standby");
    pop_pulse_a: assert property (O_STACK_POP |=> !O_STACK_POP) else $error("pop too long");
    // Answers hold until taken, arrive on time and block new requests
    bresp_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("write answer dropped");
    rdata_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read answer dropped");
    wr_answer_a: assert property (wr_taken |-> ##2 O_BVALID) else $error("late write answer");
    rd_answer_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID) else $error("late read");
    aw_block_a: assert property (O_BVALID |-> !O_AWREADY) else $error("early address");
    ar_block_a: assert property (O_RVALID |-> !O_ARREADY) else $error("early read");
endmodule
bind bfx_exec bfx_exec_properties bfx_exec_properties_inst (.*);

// File: test/tb_bfx_exec.sv
// Self-checking bench for the byte-file executor
`timescale 1ns/100ps
module tb_bfx_exec;
    logic        clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic        standby, global_interrupt_enable, wdt_clr, stack_pop;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, r;
    int          n_errors = 0, checked = 0, pops = 0, wdts = 0;
    always #10 clk = ~clk;
    // Count one-cycle pulses
    always @(posedge clk) begin
        pops <= pops + int'(stack_pop);
        wdts <= wdts + int'(wdt_clr);
    end
    bfx_exec bfx_exec_inst (
        .I_CORE_CLK(clk), .I_NRST(nrst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .O_STANDBY(standby),
        .O_GIE(global_interrupt_enable), .O_WDT_CLR(wdt_clr), .O_STACK_POP(stack_pop));
    task end_of_test;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    // A used-up wait is a hang
    task tmo(input int n);
        if (n >= 40) begin
            n_errors++;
            end_of_test();
        end
    endtask
    // Bus write; response in r
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        r = bresp;
        bready <= 1'b0;
        tmo(n);
    endtask
    // Bus read; data in v, response in r
    task rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 40);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        tmo(n);
    endtask
    function automatic logic [13:0] fo(input logic [3:0] op, input logic d);
        return {2'b00, op, d, 7'h05};
    endfunction
    function automatic logic [13:0] lo(input logic [3:0] op, input logic [7:0] k);
        return {2'b11, op, k};
    endfunction
    // Submit, then poll busy
    task run(input logic [13:0] op);
        int n;
        wr(8'h00, {18'h0, op});
        chk("instr resp", 32'h0, {30'h0, r});
        n = 0;
        do begin
            rd(8'h08);
            n++;
        end while (v[7] !== 1'b0 && n < 40);
        tmo(n);
    endtask
    // Preset, run, compare
    task tc(input logic [7:0] a, f, input logic [2:0] p, input logic [13:0] op,
            input logic [7:0] ea, ef, input logic [2:0] efl);
        wr(8'h04, {24'h0, a});
        wr(8'h18, {24'h0, f});
        wr(8'h08, {29'h0, p});
        run(op);
        rd(8'h04);
        chk("acc", {24'h0, ea}, v);
        rd(8'h18);
        chk("file", {24'h0, ef}, v);
        rd(8'h08);
        chk("flags", {29'h0, efl}, {29'h0, v[2:0]});
    endtask
    task t_bus;
        rd(8'h08);
        chk("reset status", 32'h18, v);
        rd(8'h1C);
        chk("unmapped rresp", 32'h2, {30'h0, r});
        wr(8'h20, 32'h5A);
        chk("unmapped bresp", 32'h2, {30'h0, r});
        $display("test bus done");
    endtask
    task t_ops;
        wr(8'h14, 32'h5);
        tc(8'h10, 8'h01, 3'h0, fo(4'h3, 1'b1), 8'h10, 8'h00, 3'h4);
        tc(8'h10, 8'h00, 3'h0, fo(4'h3, 1'b0), 8'hFF, 8'h00, 3'h0);
        tc(8'h10, 8'h05, 3'h1, fo(4'hB, 1'b1), 8'h10, 8'h04, 3'h1);
        tc(8'h10, 8'hFF, 3'h0, fo(4'hA, 1'b0), 8'h00, 8'hFF, 3'h4);
        tc(8'h10, 8'h7F, 3'h1, fo(4'hF, 1'b1), 8'h10, 8'h80, 3'h1);
        tc(8'h00, 8'h11, 3'h0, lo(4'h8, 8'h00), 8'h00, 8'h11, 3'h4);
        tc(8'h0F, 8'hF0, 3'h0, fo(4'h4, 1'b1), 8'h0F, 8'hFF, 3'h0);
        tc(8'h33, 8'h11, 3'h3, lo(4'h0, 8'h00), 8'h00, 8'h11, 3'h3);
        tc(8'h00, 8'h55, 3'h2, fo(4'h0, 1'b1), 8'h00, 8'h00, 3'h2);
        tc(8'h12, 8'h00, 3'h0, fo(4'h8, 1'b1), 8'h12, 8'h00, 3'h4);
        tc(8'h00, 8'h80, 3'h4, fo(4'h8, 1'b0), 8'h80, 8'h80, 3'h0);
        tc(8'h00, 8'h80, 3'h0, fo(4'hD, 1'b1), 8'h00, 8'h00, 3'h1);
        tc(8'h00, 8'h01, 3'h5, fo(4'hC, 1'b0), 8'h80, 8'h01, 3'h5);
        tc(8'h01, 8'h00, 3'h0, lo(4'hC, 8'h10), 8'h0F, 8'h00, 3'h1);
        tc(8'h05, 8'h05, 3'h0, fo(4'h2, 1'b1), 8'h05, 8'h00, 3'h7);
        tc(8'h01, 8'h00, 3'h7, fo(4'h2, 1'b0), 8'hFF, 8'h00, 3'h0);
        tc(8'h00, 8'hA5, 3'h7, fo(4'hE, 1'b0), 8'h5A, 8'hA5, 3'h7);
        tc(8'h3C, 8'h00, 3'h0, lo(4'hA, 8'h3C), 8'h00, 8'h00, 3'h4);
        tc(8'hFF, 8'h0F, 3'h0, fo(4'h6, 1'b1), 8'hFF, 8'hF0, 3'h0);
        tc(8'h00, 8'h00, 3'h5, lo(4'h4, 8'h42), 8'h42, 8'h00, 3'h5);
        $display("test ops done");
    endtask
    // Zero result discards the next one
    task t_skip(input logic [13:0] op, input logic [7:0] f, ef);
        tc(8'h00, f, 3'h0, op, 8'h00, ef, 3'h0);
        chk("skip set", 32'h1, {31'h0, v[6]});
        run(lo(4'h0, 8'h77));
        rd(8'h04);
        chk("acc after skip", 32'h0, v);
        $display("test skip done");
    endtask
    task t_ret;
        int k;
        k = pops;
        wr(8'h0C, 32'h123);
        run(14'h0008);
        rd(8'h10);
        chk("pc", 32'h123, v);
        chk("pops", k + 1, pops);
        run(14'h0009);
        chk("gie", 32'h1, {31'h0, global_interrupt_enable});
        chk("pops", k + 2, pops);
        $display("test returns done");
    endtask
    task t_sleep;
        run(14'h0063);
        chk("standby", 32'h1, {31'h0, standby});
        chk("to pd", 32'h2, {30'h0, v[4:3]});
        chk("wdt clears", 32'h1, wdts);
        wr(8'h00, {18'h0, lo(4'h0, 8'h01)});
        chk("instr in standby", 32'h2, {30'h0, r});
        wr(8'h08, 32'h0);
        rd(8'h08);
        chk("woken", 32'h0, {31'h0, v[8]});
        $display("test sleep done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_bus();
        t_ops();
        t_skip(fo(4'hB, 1'b1), 8'h01, 8'h00);
        t_skip(fo(4'hF, 1'b0), 8'hFF, 8'hFF);
        t_ret();
        t_sleep();
        end_of_test();
    end
endmodule
